// *** rtl/pwm_generator_a.sv ***
// PWM generator A: enable, load-okay reload, reload flag and AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
`include "pwm_a_defines.svh"

module pwm_generator_a (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [5:0] pwm_o,
  output logic irq_o
);

  logic [7:0] aw_addr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_full_r;
  logic w_full_r;
  logic wr_do;
  logic wr_map;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic rd_map;
  logic ar_fire;
  logic [31:0] rd_word;
  logic wr_enc;
  logic wr_fqc;
  logic wr_mod;
  logic wr_cfg;
  logic wr_ovr;
  logic rd_enc;
  logic rd_fqc;

  logic gen_a_enable_r;
  logic load_okay_a_r;
  logic load_arm_r;
  logic reload_irq_enable_a_r;
  logic reload_flag_a_r;
  logic flag_arm_r;
  logic [3:0] reload_frequency_a_r;
  logic [3:0] freq_act_r;
  logic half_cycle_reload_a_r;
  logic [1:0] clock_divider_a_r;
  logic [1:0] div_act_r;
  logic [14:0] period_modulus_a_r;
  logic [14:0] mod_act_r;
  logic [15:0] channel_pulse_widths_r [`PWMA_NUM_CH];
  logic [15:0] wid_act_r [`PWMA_NUM_CH];
  logic multi_generator_mode_r;
  logic center_r;
  logic [5:0] output_override_control_r;
  logic [5:0] ovr_val_r;
  logic [3:0] opp_cnt_r;
  logic opp;
  logic reload;
  logic [14:0] gen_a_count;
  pwm_a_pkg::tb_cfg_t tb_cfg;
  pwm_a_pkg::tb_evt_t tb_evt;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // Write channel: address and data taken in either order
  assign wr_do = aw_full_r && w_full_r && !s_axi_bvalid_o;
  assign wr_idx = aw_addr_r[7:2];
  assign wr_enc = wr_do && wr_map && wr_idx == `PWMA_IDX_ENC && wstrb_r[0];
  assign wr_fqc = wr_do && wr_map && wr_idx == `PWMA_IDX_FQC && wstrb_r[0];
  assign wr_mod = wr_do && wr_map && wr_idx == `PWMA_IDX_MOD;
  assign wr_cfg = wr_do && wr_map && wr_idx == `PWMA_IDX_CFG && wstrb_r[0];
  assign wr_ovr = wr_do && wr_map && wr_idx == `PWMA_IDX_OVR;

  always_comb
  begin
    wr_map = 1'b0;
    if (aw_addr_r[1:0] != 2'h0)
      wr_map = 1'b0;
    else if (wr_idx[5:4] == 2'h1 && !wr_idx[0] && wr_idx[3:1] < 3'h6)
      wr_map = 1'b1;
    else if (wr_idx == `PWMA_IDX_ENC || wr_idx == `PWMA_IDX_FQC || wr_idx == `PWMA_IDX_CNT)
      wr_map = 1'b1;
    else if (wr_idx == `PWMA_IDX_MOD || wr_idx == `PWMA_IDX_CFG || wr_idx == `PWMA_IDX_OVR)
      wr_map = 1'b1;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `PWMA_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_addr_r <= s_axi_awaddr_i;
        aw_full_r <= 1'b1;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
        w_full_r <= 1'b1;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_do)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_map ? `PWMA_RESP_OKAY : `PWMA_RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // Read channel
  assign rd_idx = s_axi_araddr_i[7:2];
  assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;
  assign rd_enc = ar_fire && rd_map && rd_idx == `PWMA_IDX_ENC;
  assign rd_fqc = ar_fire && rd_map && rd_idx == `PWMA_IDX_FQC;

  always_comb
  begin
    rd_map = 1'b1;
    rd_word = 32'h00000000;
    if (s_axi_araddr_i[1:0] != 2'h0)
      rd_map = 1'b0;
    else if (rd_idx[5:4] == 2'h1 && !rd_idx[0] && rd_idx[3:1] < 3'h6)
      rd_word = {16'h0000, channel_pulse_widths_r[rd_idx[3:1]]};
    else if (rd_idx == `PWMA_IDX_ENC)
      rd_word = {24'h000000, gen_a_enable_r, 5'h00, load_okay_a_r, reload_irq_enable_a_r};
    else if (rd_idx == `PWMA_IDX_FQC)
      rd_word = {24'h000000, reload_frequency_a_r, half_cycle_reload_a_r, clock_divider_a_r,
                 reload_flag_a_r};
    else if (rd_idx == `PWMA_IDX_CNT)
      rd_word = {17'h00000, gen_a_count};
    else if (rd_idx == `PWMA_IDX_MOD)
      rd_word = {17'h00000, period_modulus_a_r};
    else if (rd_idx == `PWMA_IDX_CFG)
      rd_word = {30'h00000000, center_r, multi_generator_mode_r};
    else if (rd_idx == `PWMA_IDX_OVR)
      rd_word = {18'h00000, ovr_val_r, 2'h0, output_override_control_r};
    else
      rd_map = 1'b0;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `PWMA_RESP_OKAY;
    end
    else if (ar_fire)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_word;
      s_axi_rresp_o <= rd_map ? `PWMA_RESP_OKAY : `PWMA_RESP_SLVERR;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // Enable control and the load-okay read-then-write handshake
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gen_a_enable_r <= 1'b0;
      reload_irq_enable_a_r <= 1'b0;
      load_okay_a_r <= 1'b0;
      load_arm_r <= 1'b0;
    end
    else
    begin
      if (wr_enc)
      begin
        gen_a_enable_r <= wdata_r[`PWMA_ENC_EN];
        reload_irq_enable_a_r <= wdata_r[`PWMA_ENC_RIE];
        load_arm_r <= 1'b0;
      end
      else if (rd_enc && !load_okay_a_r)
        load_arm_r <= 1'b1;
      // A fresh set wins over the clear made by a reload in the same cycle
      if (wr_enc && wdata_r[`PWMA_ENC_LDOK] && load_arm_r)
        load_okay_a_r <= 1'b1;
      else if (wr_enc && !wdata_r[`PWMA_ENC_LDOK])
        load_okay_a_r <= 1'b0;
      else if (reload)
        load_okay_a_r <= 1'b0;
    end
  end

  // Frequency control, mode and override registers
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reload_frequency_a_r <= 4'h0;
      half_cycle_reload_a_r <= 1'b0;
      clock_divider_a_r <= 2'h0;
      period_modulus_a_r <= `PWMA_MOD_RST;
      multi_generator_mode_r <= 1'b0;
      center_r <= 1'b0;
      output_override_control_r <= 6'h00;
      ovr_val_r <= 6'h00;
    end
    else
    begin
      if (wr_fqc)
      begin
        reload_frequency_a_r <= wdata_r[`PWMA_FQC_LDFQ_HI:`PWMA_FQC_LDFQ_LO];
        half_cycle_reload_a_r <= wdata_r[`PWMA_FQC_HALF];
        clock_divider_a_r <= wdata_r[`PWMA_FQC_PRSC_HI:`PWMA_FQC_PRSC_LO];
      end
      if (wr_mod && wstrb_r[0])
        period_modulus_a_r[7:0] <= wdata_r[7:0];
      if (wr_mod && wstrb_r[1])
        period_modulus_a_r[14:8] <= wdata_r[14:8];
      if (wr_cfg)
      begin
        multi_generator_mode_r <= wdata_r[`PWMA_CFG_MTG];
        center_r <= wdata_r[`PWMA_CFG_CENTER];
      end
      if (wr_ovr && wstrb_r[0])
        output_override_control_r <= wdata_r[5:0];
      if (wr_ovr && wstrb_r[1])
        ovr_val_r <= wdata_r[`PWMA_OVR_VAL_LO +: 6];
    end
  end

  // Time base runs on the active, not the buffered, divider and modulus; center and half-cycle come straight from the registers
  assign tb_cfg.div = div_act_r;
  assign tb_cfg.modulus = mod_act_r;
  assign tb_cfg.center = center_r;
  assign tb_cfg.half = half_cycle_reload_a_r;

  pwm_a_timebase u_timebase (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .run_i(gen_a_enable_r),
    .cfg_i(tb_cfg),
    .count_o(gen_a_count),
    .evt_o(tb_evt)
  );

  assign opp = tb_evt.full || tb_evt.half;
  assign reload = gen_a_enable_r && opp && opp_cnt_r == freq_act_r;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      opp_cnt_r <= 4'h0;
    else if (!gen_a_enable_r || reload)
      opp_cnt_r <= 4'h0;
    else if (opp)
      opp_cnt_r <= opp_cnt_r + 4'h1;
  end

  // Divider and modulus move into use at reload only with load-okay; reload frequency at every reload
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      freq_act_r <= 4'h0;
      div_act_r <= 2'h0;
      mod_act_r <= `PWMA_MOD_RST;
    end
    else if (reload)
    begin
      freq_act_r <= reload_frequency_a_r;
      if (load_okay_a_r)
      begin
        div_act_r <= clock_divider_a_r;
        mod_act_r <= period_modulus_a_r;
      end
    end
  end

  // Reload flag; a reload in the clear cycle voids the clear
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reload_flag_a_r <= 1'b0;
      flag_arm_r <= 1'b0;
    end
    else
    begin
      if (reload)
        reload_flag_a_r <= 1'b1;
      else if (wr_fqc && wdata_r[`PWMA_FQC_RF] && flag_arm_r)
        reload_flag_a_r <= 1'b0;
      if (reload)
        flag_arm_r <= 1'b0;
      else if (rd_fqc && reload_flag_a_r)
        flag_arm_r <= 1'b1;
      else if (wr_fqc)
        flag_arm_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= reload_flag_a_r && reload_irq_enable_a_r;
  end

  // Per-channel width buffers, loads and output compare
  generate
    for (genvar k = 0; k < `PWMA_NUM_CH; k++)
    begin : g_ch
      logic governed;
      logic w_pos;
      logic w_full;
      assign governed = (k < 2) || !multi_generator_mode_r;
      assign w_pos = !wid_act_r[k][15] && wid_act_r[k] != 16'h0000;
      assign w_full = !wid_act_r[k][15] && wid_act_r[k][14:0] >= mod_act_r;

      always_ff @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
          channel_pulse_widths_r[k] <= `PWMA_WID_RST;
        else if (wr_do && wr_map && wr_idx == `PWMA_IDX_VAL0 + 6'(2 * k))
        begin
          if (wstrb_r[0])
            channel_pulse_widths_r[k][7:0] <= wdata_r[7:0];
          if (wstrb_r[1])
            channel_pulse_widths_r[k][15:8] <= wdata_r[15:8];
        end
      end

      always_ff @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
          wid_act_r[k] <= `PWMA_WID_RST;
        else if (reload && load_okay_a_r && governed)
          wid_act_r[k] <= channel_pulse_widths_r[k];
      end

      always_ff @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
          pwm_o[k] <= 1'b0;
        else if (output_override_control_r[k])
          pwm_o[k] <= ovr_val_r[k];
        else if (!gen_a_enable_r || !governed)
          pwm_o[k] <= 1'b0;
        else
          pwm_o[k] <= w_full || (w_pos && gen_a_count < wid_act_r[k][14:0]);
      end
    end
  endgenerate

  ldok_auto_clr_a: assert property (reload && load_okay_a_r && !wr_enc |=> !load_okay_a_r)
    else $error("load okay not cleared after reload");
  ldok_needs_read_a: assert property ($rose(load_okay_a_r) |-> $past(load_arm_r))
    else $error("load okay set without prior read");
  rf_set_a: assert property (reload |=> reload_flag_a_r [*2])
    else $error("reload flag not set after reload");
  rf_clr_read_a: assert property ($fell(reload_flag_a_r) |->
    $past(flag_arm_r) && !$past(reload))
    else $error("reload flag cleared without valid sequence");
  irq_gate_a: assert property (!reload_irq_enable_a_r ##1 !reload_irq_enable_a_r |->
    !irq_o)
    else $error("interrupt raised while disabled");
  irq_withdraw_a: assert property ($fell(reload_flag_a_r) |=> !irq_o)
    else $error("interrupt stayed after flag clear");
  cnt_read_a: assert property (ar_fire && rd_idx == `PWMA_IDX_CNT && rd_map |=>
    s_axi_rdata_o == {17'h00000, $past(gen_a_count)})
    else $error("counter read mismatch");
  ch_disabled_a: assert property (!gen_a_enable_r && !output_override_control_r[0] |=>
    !pwm_o[0])
    else $error("channel driven while disabled");
  mtg_pin_a: assert property (multi_generator_mode_r && !output_override_control_r[3] |=>
    !pwm_o[3])
    else $error("pin outside generator A driven in multi mode");
  mtg_load_a: assert property (reload && multi_generator_mode_r |=> $stable(wid_act_r[4]))
    else $error("width of other generator loaded");
  half_edge_a: assert property (tb_evt.half |-> center_r && half_cycle_reload_a_r)
    else $error("half opportunity outside center mode");
  freq_count_a: assert property (reload |-> opp_cnt_r == freq_act_r ##1 opp_cnt_r == 4'h0)
    else $error("reload spacing wrong");

  load_cov_c: cover property (reload && load_okay_a_r);
  rf_clr_c: cover property ($fell(reload_flag_a_r));
  half_cov_c: cover property (reload && tb_evt.half);
  irq_cov_c: cover property ($rose(irq_o));

endmodule : pwm_generator_a
`default_nettype wire

// *** rtl/pwm_a_defines.svh ***
// Register indices, field positions, reset values and bus codes for PWM generator A
`ifndef PWM_A_DEFINES_SVH
`define PWM_A_DEFINES_SVH

// Register indices; byte address is four times the index
`define PWMA_IDX_VAL0 6'h10
`define PWMA_IDX_ENC 6'h20
`define PWMA_IDX_FQC 6'h21
`define PWMA_IDX_CNT 6'h22
`define PWMA_IDX_MOD 6'h24
`define PWMA_IDX_CFG 6'h30
`define PWMA_IDX_OVR 6'h31
`define PWMA_NUM_CH 6

// Enable control fields
`define PWMA_ENC_EN 7
`define PWMA_ENC_LDOK 1
`define PWMA_ENC_RIE 0

// Frequency control fields
`define PWMA_FQC_LDFQ_HI 7
`define PWMA_FQC_LDFQ_LO 4
`define PWMA_FQC_HALF 3
`define PWMA_FQC_PRSC_HI 2
`define PWMA_FQC_PRSC_LO 1
`define PWMA_FQC_RF 0

// Mode and override fields
`define PWMA_CFG_MTG 0
`define PWMA_CFG_CENTER 1
`define PWMA_OVR_VAL_LO 8

// Reset values
`define PWMA_MOD_RST 15'h0001
`define PWMA_WID_RST 16'h0000

// Prescaler terminal counts for divide by 1, 2, 4, 8
`define PWMA_DIV1_TC 3'h0
`define PWMA_DIV2_TC 3'h1
`define PWMA_DIV4_TC 3'h3
`define PWMA_DIV8_TC 3'h7

// Bus responses
`define PWMA_RESP_OKAY 2'h0
`define PWMA_RESP_SLVERR 2'h2

`endif

// *** rtl/pwm_a_pkg.sv ***
// Types shared by the PWM generator A files
package pwm_a_pkg;

  typedef struct packed {
    logic [1:0] div;
    logic [14:0] modulus;
    logic center;
    logic half;
  } tb_cfg_t;

  typedef struct packed {
    logic full;
    logic half;
  } tb_evt_t;

  typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

endpackage : pwm_a_pkg

// *** rtl/pwm_a_timebase.sv ***
// Prescaler and 15-bit up or up/down counter of generator A
`timescale 1ns/1ns
`default_nettype none
`include "pwm_a_defines.svh"

module pwm_a_timebase (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire pwm_a_pkg::tb_cfg_t cfg_i,
  output logic [14:0] count_o,
  output pwm_a_pkg::tb_evt_t evt_o
);

  logic [2:0] div_cnt_r;
  logic [2:0] div_tc;
  logic tick;
  pwm_a_pkg::count_dir_t dir_r;

  always_comb
  begin
    case (cfg_i.div)
      2'h0: div_tc = `PWMA_DIV1_TC;
      2'h1: div_tc = `PWMA_DIV2_TC;
      2'h2: div_tc = `PWMA_DIV4_TC;
      default: div_tc = `PWMA_DIV8_TC;
    endcase
  end

  assign tick = (div_cnt_r >= div_tc);

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      div_cnt_r <= 3'h0;
    else if (!run_i || tick)
      div_cnt_r <= 3'h0;
    else
      div_cnt_r <= div_cnt_r + 3'h1;
  end

  // Edge mode counts 0..mod-1; center mode counts 0..mod..0
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_o <= 15'h0000;
      dir_r <= pwm_a_pkg::DIR_UP;
      evt_o <= '0;
    end
    else if (!run_i)
    begin
      count_o <= 15'h0000;
      dir_r <= pwm_a_pkg::DIR_UP;
      evt_o <= '0;
    end
    else
    begin
      evt_o <= '0;
      if (tick)
      begin
        if (!cfg_i.center)
        begin
          if ({1'b0, count_o} + 16'h0001 >= {1'b0, cfg_i.modulus})
          begin
            count_o <= 15'h0000;
            evt_o.full <= 1'b1;
          end
          else
            count_o <= count_o + 15'h0001;
        end
        else
        begin
          case (dir_r)
            pwm_a_pkg::DIR_UP:
            begin
              if ({1'b0, count_o} + 16'h0001 >= {1'b0, cfg_i.modulus})
              begin
                count_o <= cfg_i.modulus;
                dir_r <= pwm_a_pkg::DIR_DOWN;
                evt_o.half <= cfg_i.half;
              end
              else
                count_o <= count_o + 15'h0001;
            end
            default:
            begin
              if (count_o <= 15'h0001)
              begin
                count_o <= 15'h0000;
                dir_r <= pwm_a_pkg::DIR_UP;
                evt_o.full <= 1'b1;
              end
              else
                count_o <= count_o - 15'h0001;
            end
          endcase
        end
      end
    end
  end

endmodule : pwm_a_timebase
`default_nettype wire

// *** tb/tb_top.sv ***
// Register-level testbench for PWM generator A
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rv;
  logic [5:0] pwm;
  logic [7:0] hc [6];
  int fails = 0;
  int samples_checked = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  pwm_generator_a pwm_generator_a_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pwm_o(pwm), .irq_o(irq));

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // Address and data offered together; bready held high from the start
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100 && !done; n++)
    begin
      @(posedge clk_sys_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        done = 1'b1;
        `CHK("bresp", er, bresp)
      end
    end
    bready <= 1'b0;
    if (!done)
    begin
      fails++;
      test_done();
    end
    @(posedge clk_sys_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100 && !done; n++)
    begin
      @(posedge clk_sys_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        done = 1'b1;
        d = rdata;
        `CHK("rresp", er, rresp)
      end
    end
    rready <= 1'b0;
    if (!done)
    begin
      fails++;
      test_done();
    end
    @(posedge clk_sys_i);
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d, 2'h0);
    `CHK("register", e, d)
  endtask : rdc

  // Counts active cycles per pin; cyc must span whole periods so phase does not matter
  task automatic hi_count(input int cyc, input logic [7:0] e0, input logic [7:0] e1,
    input logic [7:0] e2, input logic [7:0] e3, input logic [7:0] e4, input logic [7:0] e5);
    logic [7:0] ex [6];
    ex = '{e0, e1, e2, e3, e4, e5};
    hc = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (cyc)
    begin
      @(posedge clk_sys_i);
      for (int k = 0; k < 6; k++) hc[k] = hc[k] + {7'h00, pwm[k]};
    end
    for (int k = 0; k < 6; k++) `CHK("pin_high_cycles", ex[k], hc[k])
  endtask : hi_count

  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    `CHK("pwm_reset", 6'h00, pwm)
    `CHK("irq_reset", 1'b0, irq)
    rdc(8'h84, 32'h0000_0000);
    rdc(8'h88, 32'h0000_0000);
    rdc(8'h90, 32'h0000_0001);
    rd(8'hFC, rv, 2'h2);
    `CHK("unmapped_data", 32'h0, rv)
    wr(8'h88, 32'h0000_0005, 2'h0);
    rdc(8'h88, 32'h0000_0000);
    // Load okay needs a read of zero first
    wr(8'h80, 32'h0000_0002, 2'h0);
    rdc(8'h80, 32'h0000_0000);
    wr(8'h80, 32'h0000_0002, 2'h0);
    rdc(8'h80, 32'h0000_0002);
    wr(8'h80, 32'h0000_0000, 2'h0);
    rdc(8'h80, 32'h0000_0000);
    wr(8'h90, 32'h0000_0004, 2'h0);
    wr(8'h40, 32'h0000_0002, 2'h0);
    wr(8'h48, 32'h0000_0000, 2'h0);
    wr(8'h50, 32'h0000_0004, 2'h0);
    wr(8'h58, 32'h0000_FFFF, 2'h0);
    wr(8'h60, 32'h0000_0005, 2'h0);
    wr(8'h68, 32'h0000_0001, 2'h0);
    rdc(8'h80, 32'h0000_0000);
    wr(8'h80, 32'h0000_0082, 2'h0);
    rv = 32'h0;
    for (int n = 0; n < 50 && rv[0] !== 1'b1; n++) rd(8'h84, rv, 2'h0);
    `CHK("reload_flag", 1'b1, rv[0])
    rdc(8'h80, 32'h0000_0080);
    hi_count(8, 8'h04, 8'h00, 8'h08, 8'h00, 8'h08, 8'h02);
    rd(8'h88, rv, 2'h0);
    `CHK("count_range", 1'b1, rv < 32'h4)
    // Disabled: pins idle, override still reaches the pins
    wr(8'h80, 32'h0000_0000, 2'h0);
    repeat (2) @(posedge clk_sys_i);
    `CHK("pwm_disabled", 6'h00, pwm)
    wr(8'hC4, 32'h0000_0103, 2'h0);
    repeat (2) @(posedge clk_sys_i);
    `CHK("pwm_override", 6'h01, pwm)
    `CHK("irq_masked", 1'b0, irq)
    wr(8'h80, 32'h0000_0001, 2'h0);
    repeat (2) @(posedge clk_sys_i);
    `CHK("irq_enabled", 1'b1, irq)
    wr(8'h84, 32'h0000_0001, 2'h0);
    rdc(8'h84, 32'h0000_0001);
    wr(8'h84, 32'h0000_0001, 2'h0);
    repeat (2) @(posedge clk_sys_i);
    `CHK("irq_withdrawn", 1'b0, irq)
    rdc(8'h84, 32'h0000_0000);
    wr(8'h84, 32'h0000_0036, 2'h0);
    rdc(8'h84, 32'h0000_0036);
    // Multi-generator mode: only pins zero and one follow the enable
    wr(8'h84, 32'h0000_0000, 2'h0);
    wr(8'hC4, 32'h0000_0000, 2'h0);
    wr(8'hC0, 32'h0000_0001, 2'h0);
    wr(8'h40, 32'h0000_0003, 2'h0);
    wr(8'h60, 32'h0000_0000, 2'h0);
    rdc(8'h80, 32'h0000_0001);
    wr(8'h80, 32'h0000_0082, 2'h0);
    repeat (8) @(posedge clk_sys_i);
    hi_count(8, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    // Width four stayed behind in multi mode; prescaler waits for load okay
    wr(8'hC0, 32'h0000_0000, 2'h0);
    wr(8'h84, 32'h0000_0004, 2'h0);
    hi_count(8, 8'h06, 8'h00, 8'h08, 8'h00, 8'h08, 8'h02);
    rdc(8'h80, 32'h0000_0080);
    wr(8'h80, 32'h0000_0082, 2'h0);
    repeat (24) @(posedge clk_sys_i);
    rdc(8'h80, 32'h0000_0080);
    hi_count(32, 8'h18, 8'h00, 8'h20, 8'h00, 8'h00, 8'h08);
    // Center mode with half-cycle reloads: 16 opportunities of 16 clocks each
    wr(8'hC0, 32'h0000_0002, 2'h0);
    wr(8'h84, 32'h0000_00FC, 2'h0);
    repeat (20) @(posedge clk_sys_i);
    rdc(8'h84, 32'h0000_00FD);
    wr(8'h84, 32'h0000_00FD, 2'h0);
    repeat (150) @(posedge clk_sys_i);
    rdc(8'h84, 32'h0000_00FC);
    rv = 32'h0;
    for (int n = 0; n < 50 && rv[0] !== 1'b1; n++) rd(8'h84, rv, 2'h0);
    `CHK("half_reload", 1'b1, rv[0])
    test_done();
  end
endmodule : tb_top

`default_nettype wire
